// ==== core/spinv_slave.sv ====
// Serial slave front end with an 8K x 8 byte array and a status register.
// Assumes the serial clock is slow enough for CORE_CLK to find each edge.
// Function
// - Chip select high: standby, ignore other pins
// - Output released whenever deselected
// - Sample input on serial clock rise
// - Change output on serial clock fall
// - Works in clock modes 0 and 3
// - Pause low suspends transfer, output released
// - Input carries op-code, address, write data
// - Output carries array or status read data
// - Array holds 8192 bytes
// - Array writes complete with no busy time
// - Status write gated by guard pin and bit
// - Six eight-bit op-codes recognised
// - Partial op-code performs no command
// - Sixteen-bit address, top three bits ignored
// - Bursts increment address and wrap to zero
`timescale 1ns/1ns
module spinv_slave
  import spinv_pkg::*;
#(
  parameter int DEPTH = SPINV_DEPTH
) (
  input  wire logic CORE_CLK,
  input  wire logic RST_N,
  input  wire logic CE,
  input  wire logic CS_N,
  input  wire logic SCK,
  input  wire logic MOSI,
  input  wire logic HOLD_N,
  input  wire logic GUARD_N,
  output logic      MISO,
  output logic      MISO_OE_N
);
  spinv_pins_t  pin_raw;
  spinv_pins_t  pin_s;
  logic [4:0]   pin_q;

  assign pin_raw = '{csn: CS_N, sck: SCK, mosi: MOSI, holdn: HOLD_N, guardn: GUARD_N};

  spinv_sync #(
    .W (5)
  ) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .d     (pin_raw),
    .q     (pin_q)
  );
  assign pin_s = pin_q;

  logic [7:0]          mem [DEPTH];
  spinv_state_t        state_ff;
  spinv_state_t        nxt_state;
  logic                sck_d_ff;
  logic                csn_d_ff;
  logic [2:0]          bit_ff;
  logic [4:0]          acnt_ff;
  logic [7:0]          sh_ff;
  logic [7:0]          op_ff;
  logic [SPINV_AW-1:0] addr_ff;
  logic [7:0]          tx_ff;
  logic [7:0]          status_ff;
  logic                wel_ff;
  logic                miso_ff;
  logic                oe_n_ff;

  // Pause gates the edges so the bit position is kept across it
  wire active     = !pin_s.csn && pin_s.holdn;
  wire sck_rise   = active && pin_s.sck && !sck_d_ff;
  wire sck_fall   = active && !pin_s.sck && sck_d_ff;
  wire cs_rise    = pin_s.csn && !csn_d_ff;
  wire [7:0] sh_n = {sh_ff[6:0], pin_s.mosi};
  wire byte_done  = sck_rise && (bit_ff == SPINV_BIT_LAST);
  wire addr_done  = sck_rise && (acnt_ff == SPINV_ADDR_LAST);
  wire [SPINV_AW-1:0] addr_inc = addr_ff + 1'b1;
  wire [SPINV_AW-1:0] addr_n   = {addr_ff[SPINV_AW-2:0], pin_s.mosi};
  wire guard_ok   = !(status_ff[SPINV_GUARD_BIT] && !pin_s.guardn);
  wire [7:0] status_rd = {status_ff[7:2], wel_ff, 1'b0};
  wire is_op      = state_ff == SPINV_S_OPC;
  wire op_set     = is_op && byte_done && sh_n == SPINV_OP_SETWL;
  wire op_clr     = is_op && byte_done && sh_n == SPINV_OP_CLRWL;
  wire wrs_done   = state_ff == SPINV_S_WRS && byte_done && wel_ff && guard_ok;
  wire wra_done   = state_ff == SPINV_S_WRA && byte_done && wel_ff;
  wire load_tx    = (state_ff == SPINV_S_RDA || state_ff == SPINV_S_RDS) && byte_done;
  wire [7:0] rd_byte = (state_ff == SPINV_S_RDS || nxt_state == SPINV_S_RDS)
                       ? status_rd : mem[addr_ff];

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SPINV_S_OPC: begin
        if (byte_done) begin
          unique case (sh_n)
            SPINV_OP_RDST:  nxt_state = SPINV_S_RDS;
            SPINV_OP_WRST:  nxt_state = SPINV_S_WRS;
            SPINV_OP_RDARR: nxt_state = SPINV_S_ADDR;
            SPINV_OP_WRARR: nxt_state = SPINV_S_ADDR;
            default:        nxt_state = SPINV_S_OPC;
          endcase
        end
      end
      SPINV_S_ADDR: begin
        if (addr_done) begin
          nxt_state = (op_ff == SPINV_OP_RDARR) ? SPINV_S_RDA : SPINV_S_WRA;
        end
      end
      SPINV_S_RDA: nxt_state = SPINV_S_RDA;
      SPINV_S_WRA: nxt_state = SPINV_S_WRA;
      SPINV_S_RDS: nxt_state = SPINV_S_RDS;
      SPINV_S_WRS: nxt_state = SPINV_S_WRS;
      default:     nxt_state = SPINV_S_OPC;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sck_d_ff <= 1'b0;
      csn_d_ff <= 1'b1;
    end else if (CE) begin
      // Edge reference follows the pin even when paused, so resuming is glitch free
      sck_d_ff <= pin_s.sck;
      csn_d_ff <= pin_s.csn;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_ff <= SPINV_S_OPC;
      bit_ff   <= 3'h0;
      acnt_ff  <= 5'h00;
      sh_ff    <= 8'h00;
      op_ff    <= 8'h00;
    end else if (CE) begin
      if (pin_s.csn || cs_rise) begin
        state_ff <= SPINV_S_OPC;
        bit_ff   <= 3'h0;
        acnt_ff  <= 5'h00;
      end else if (sck_rise) begin
        state_ff <= nxt_state;
        bit_ff   <= bit_ff + 3'h1;
        sh_ff    <= sh_n;
        if (is_op && byte_done) begin
          op_ff <= sh_n;
        end
        if (state_ff == SPINV_S_ADDR) begin
          acnt_ff <= acnt_ff + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      addr_ff <= '0;
    end else if (CE) begin
      if (state_ff == SPINV_S_ADDR && sck_rise) begin
        addr_ff <= addr_n;
      end else if ((wra_done || load_tx && state_ff == SPINV_S_RDA) || 
                   (state_ff == SPINV_S_WRA && byte_done && !wel_ff)) begin
        addr_ff <= addr_inc;
      end
    end
  end

  // Array write lands on the last data bit; no busy period follows
  always_ff @(posedge CORE_CLK) begin
    if (CE && wra_done) begin
      mem[addr_ff] <= sh_n;
    end
  end

  // Write latch clears at deselect after an array or status write command
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      status_ff <= SPINV_ST_RST;
      wel_ff    <= 1'b0;
    end else if (CE) begin
      if (wrs_done) begin
        status_ff <= (sh_n & SPINV_ST_WMASK) | (status_ff & ~SPINV_ST_WMASK);
      end
      if (op_set) begin
        wel_ff <= 1'b1;
      end else if (op_clr) begin
        wel_ff <= 1'b0;
      end else if (cs_rise && (op_ff == SPINV_OP_WRST || op_ff == SPINV_OP_WRARR)
                   && state_ff != SPINV_S_OPC) begin
        wel_ff <= 1'b0;
      end
    end
  end

  // Transmit shifter: reloaded at each byte boundary, first bit out on the next fall
  wire enter_rd = sck_rise && ((state_ff == SPINV_S_ADDR && addr_done &&
                  op_ff == SPINV_OP_RDARR) || (is_op && byte_done && sh_n == SPINV_OP_RDST));
  logic [7:0] tx_src;
  assign tx_src = (state_ff == SPINV_S_RDA && load_tx) ? mem[addr_inc] :
                  (state_ff == SPINV_S_ADDR) ? mem[addr_n] : rd_byte;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tx_ff   <= 8'h00;
      miso_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else if (CE) begin
      oe_n_ff <= !(active && (state_ff == SPINV_S_RDA || state_ff == SPINV_S_RDS));
      if (enter_rd || load_tx) begin
        tx_ff <= tx_src;
      end else if (sck_fall && (state_ff == SPINV_S_RDA || state_ff == SPINV_S_RDS)) begin
        miso_ff <= tx_ff[7];
        tx_ff   <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  assign MISO      = miso_ff;
  assign MISO_OE_N = oe_n_ff;
endmodule : spinv_slave

// ==== core/spinv_sync.sv ====
// Two-flop synchroniser bank for the asynchronous pin inputs.
// Assumes the pins are quasi-static relative to the core clock period.
`timescale 1ns/1ns
module spinv_sync
  import spinv_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_ff[i] <= 1'b1;
          q[i]       <= 1'b1;
        end else if (ce) begin
          meta_ff[i] <= d[i];
          q[i]       <= meta_ff[i];
        end
      end
    end
  endgenerate
endmodule : spinv_sync

// ==== pkg/spinv_pkg.sv ====
// Constants and carrier types for the serial nonvolatile memory slave front end.
// Assumes one core clock that oversamples the serial clock by a wide margin.
package spinv_pkg;
  localparam int          SPINV_DEPTH     = 8192;
  localparam int          SPINV_AW        = 13;
  localparam int          SPINV_SPI_AW    = 16;
  localparam logic [7:0]  SPINV_OP_SETWL  = 8'h06;
  localparam logic [7:0]  SPINV_OP_CLRWL  = 8'h04;
  localparam logic [7:0]  SPINV_OP_RDST   = 8'h05;
  localparam logic [7:0]  SPINV_OP_WRST   = 8'h01;
  localparam logic [7:0]  SPINV_OP_RDARR  = 8'h03;
  localparam logic [7:0]  SPINV_OP_WRARR  = 8'h02;
  localparam int          SPINV_GUARD_BIT = 7;
  localparam int          SPINV_WEL_BIT   = 1;
  localparam logic [7:0]  SPINV_ST_RST    = 8'h00;
  localparam logic [7:0]  SPINV_ST_WMASK  = 8'hFC;
  localparam logic [2:0]  SPINV_BIT_LAST  = 3'h7;
  localparam logic [4:0]  SPINV_ADDR_LAST = 5'h0F;

  typedef enum logic [5:0] {
    SPINV_S_OPC  = 6'b000001,
    SPINV_S_ADDR = 6'b000010,
    SPINV_S_RDA  = 6'b000100,
    SPINV_S_WRA  = 6'b001000,
    SPINV_S_RDS  = 6'b010000,
    SPINV_S_WRS  = 6'b100000
  } spinv_state_t;

  typedef struct packed {
    logic csn;
    logic sck;
    logic mosi;
    logic holdn;
    logic guardn;
  } spinv_pins_t;
endpackage : spinv_pkg

// ==== tb/spinv_master.sv ====
// Serial master model; pins change at the core clock's falling edge.
// Assumes a 160 ns serial clock, ten core cycles per half period.
`timescale 1ns/1ns
module spinv_master (
  input  wire logic clk,
  input  wire logic miso,
  output logic      cs_n,
  output logic      sck,
  output logic      mosi,
  output logic      hold_n
);
  logic cpol = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    hold_n = 1'b1;
  end
  task automatic half;
    repeat (10) @(negedge clk);
  endtask : half
  // Clock stands still between frames at the idle level of the mode
  task automatic sel(input logic mode3);
    cpol = mode3;
    sck <= mode3;
    half();
    cs_n <= 1'b0;
    half();
  endtask : sel
  task automatic desel;
    half();
    sck <= cpol;
    half();
    cs_n <= 1'b1;
    mosi <= ~mosi;
    half();
  endtask : desel
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sck <= 1'b0;
      mosi <= tx[i];
      half();
      rx[i] = miso;
      sck <= 1'b1;
      half();
    end
  endtask : xfer
  // Garbage edges during the pause must be ignored by the slave
  task automatic pause;
    hold_n <= 1'b0;
    repeat (4) begin
      half();
      sck <= ~sck;
      mosi <= ~mosi;
    end
    half();
    hold_n <= 1'b1;
    half();
  endtask : pause
endmodule : spinv_master

// ==== tb/spinv_slave_properties.sv ====
// Pin-level checks on the serial slave front end.
// Assumes the core clock oversamples SCK by ten cycles per half period.
`timescale 1ns/1ns
module spinv_properties (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic HOLD_N,
  input wire logic MISO,
  input wire logic MISO_OE_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_standby_release: assert property (CS_N [*5] |-> MISO_OE_N)
    else $error("output driven while deselected");
  a_standby_quiet: assert property (CS_N [*6] |-> $stable(MISO))
    else $error("output moved in standby");
  a_pause_release: assert property (!HOLD_N [*6] |-> MISO_OE_N)
    else $error("output driven during pause");
  a_hold_keeps_level: assert property (!HOLD_N [*6] |-> $stable(MISO))
    else $error("output moved during pause");
  a_shift_on_fall: assert property ($changed(MISO) && !MISO_OE_N && $past(!MISO_OE_N)
    |-> !$past(SCK, 2)) else $error("output changed away from a falling edge");
  a_stable_while_high: assert property (SCK && $past(SCK, 6) && $past(!MISO_OE_N)
    |-> $stable(MISO)) else $error("output changed while clock high");
  a_oe_when_selected: assert property ($fell(MISO_OE_N) |-> !CS_N && HOLD_N)
    else $error("output enabled outside an active transfer");
  a_release_on_deselect: assert property ($rose(CS_N) |-> ##[1:6] MISO_OE_N)
    else $error("output not released after deselect");
  cover property ($fell(MISO_OE_N));
  cover property (!HOLD_N && !CS_N);
  cover property ($rose(CS_N));
endmodule : spinv_properties

// ==== tb/test_spinv_slave.sv ====
// Self-checking bench: master model talks to the slave front end.
// Assumes a released output line shows the inverse of its last value.
`timescale 1ns/1ns
module test_spinv_slave;
  import spinv_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n    = 1'b0;
  logic       guard_n  = 1'b1;
  logic       mode3    = 1'b0;
  logic       cs_n, sck, mosi, hold_n, miso, miso_oe_n, miso_wire;
  logic [7:0] rx;
  int         fail_count = 0;
  int         cmp_count  = 0;
  int         cycles     = 0;
  always #4 core_clk = ~core_clk;
  assign miso_wire = miso_oe_n ? ~miso : miso;
  spinv_master spinv_master_i (.clk(core_clk), .miso(miso_wire), .cs_n(cs_n), .sck(sck),
    .mosi(mosi), .hold_n(hold_n));
  spinv_slave spinv_slave_i (.CORE_CLK(core_clk), .RST_N(rst_n), .CE(1'b1), .CS_N(cs_n),
    .SCK(sck), .MOSI(mosi), .HOLD_N(hold_n), .GUARD_N(guard_n), .MISO(miso),
    .MISO_OE_N(miso_oe_n));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] code, input logic [15:0] addr, input bit with_addr);
    spinv_master_i.sel(mode3);
    spinv_master_i.xfer(code, 8, rx);
    if (with_addr) begin
      spinv_master_i.xfer(addr[15:8], 8, rx);
      spinv_master_i.xfer(addr[7:0], 8, rx);
    end
  endtask : cmd
  task automatic rd_status(input logic [7:0] mask, input logic [7:0] exp);
    cmd(SPINV_OP_RDST, 16'h0000, 1'b0);
    spinv_master_i.xfer(8'h00, 8, rx);
    check(rx & mask, exp);
    spinv_master_i.desel();
  endtask : rd_status
  task automatic t_array;
    mode3 = 1'b0;
    cmd(SPINV_OP_SETWL, 16'h0000, 1'b0);
    spinv_master_i.desel();
    cmd(SPINV_OP_WRARR, 16'hFFFF, 1'b1);
    spinv_master_i.xfer(8'hA5, 8, rx);
    spinv_master_i.xfer(8'h3C, 8, rx);
    spinv_master_i.desel();
    cmd(SPINV_OP_RDARR, 16'h1FFF, 1'b1);
    spinv_master_i.xfer(8'h00, 8, rx);
    check(rx, 8'hA5);
    check({7'h00, miso_oe_n}, 8'h00);
    spinv_master_i.pause();
    spinv_master_i.xfer(8'h00, 8, rx);
    check(rx, 8'h3C);
    spinv_master_i.desel();
    $display("array test done");
  endtask : t_array
  task automatic t_status;
    mode3 = 1'b1;
    rd_status(8'hFF, 8'h00);
    cmd(SPINV_OP_SETWL, 16'h0000, 1'b0);
    spinv_master_i.desel();
    rd_status(8'hFF, 8'h02);
    cmd(SPINV_OP_CLRWL, 16'h0000, 1'b0);
    spinv_master_i.desel();
    rd_status(8'hFF, 8'h00);
    cmd(SPINV_OP_SETWL, 16'h0000, 1'b0);
    spinv_master_i.desel();
    cmd(SPINV_OP_WRST, 16'h0000, 1'b0);
    spinv_master_i.xfer(8'h8F, 8, rx);
    spinv_master_i.desel();
    rd_status(8'hFF, 8'h8C);
    guard_n = 1'b0;
    cmd(SPINV_OP_SETWL, 16'h0000, 1'b0);
    spinv_master_i.desel();
    cmd(SPINV_OP_WRST, 16'h0000, 1'b0);
    spinv_master_i.xfer(8'h00, 8, rx);
    spinv_master_i.desel();
    rd_status(8'hFC, 8'h8C);
    $display("status test done");
  endtask : t_status
  task automatic t_partial;
    mode3 = 1'b0;
    spinv_master_i.sel(mode3);
    spinv_master_i.xfer(SPINV_OP_SETWL, 7, rx);
    spinv_master_i.desel();
    cmd(SPINV_OP_WRARR, 16'h0000, 1'b1);
    spinv_master_i.xfer(8'h77, 8, rx);
    spinv_master_i.desel();
    cmd(SPINV_OP_RDARR, 16'h0000, 1'b1);
    spinv_master_i.xfer(8'h00, 8, rx);
    check(rx, 8'h3C);
    spinv_master_i.desel();
    $display("partial test done");
  endtask : t_partial
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      $display("unexpected at %0t: run timed out", $time);
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    t_array();
    t_status();
    t_partial();
    print_verdict();
  end
endmodule : test_spinv_slave
bind spinv_slave spinv_properties spinv_properties_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .CS_N(CS_N), .SCK(SCK), .HOLD_N(HOLD_N), .MISO(MISO), .MISO_OE_N(MISO_OE_N));
